// ===== hw/smmx_top.sv
// Function
// RULE1: A dual-monitor activating SMM exit loads no MSRs from the exit load list.
// RULE2: Entry with deactivate control set returns processor to default SMI handling.
// RULE3: Deactivation fails outside SMM, with entry-to-SMM set, or pointer mismatch.
// RULE4: Deactivating entry ignores the guest SMI-blocking interruptibility bit.
// RULE5: In safer mode SMIs stay blocked after deactivation until leave or leaf.
// RULE6: Outside safer mode SMIs are unblocked after deactivation.
// RULE7: Safer mode holds from launch leaf until a later exit leaf.
// RULE8: No extended state is saved on an SMI; handler preserves it.
// RULE9: With checking on, SMM fetch outside protected ranges raises machine check.
// RULE10: Code check enable lives in package-wide register 4E0H.
// RULE11: Writes to 4E0H only allowed as the capability register 17DH permits.
// RULE12: SMIs are taken only at instruction boundaries; long flows delay them.
// RULE13: Register 4E2H reports per-processor SMI delay and holds its enable.
// RULE14: Register 4E2H availability is governed by capability register 17DH.
// RULE15: Register 4E3H reports which processors are blocked from SMI service.
// RULE16: Access to 4E0H, 4E2H or 4E3H outside SMM raises general protection.
// RULE17: Every register is reachable by read and write MSR instructions by address; here writes to 17DH and 4E3H raise general protection.
// RULE18: Each processor owns a fixed bit index in delay and blocked registers.
`timescale 1ns/100ps
`default_nettype none
`include "smmx_map.svh"
module smmx_top
   import smmx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // MSR access from the requesting logical processor
   input wire logic msr_rd,
   input wire logic msr_wr,
   input wire logic [11:0] msr_addr,
   input wire logic [63:0] msr_wdata,
   input wire logic [1:0] msr_lp,
   output logic [63:0] msr_rdata_q,
   output logic [1:0] msr_res_q,
   // Per logical processor state
   input wire logic [SMMX_NLP-1:0] in_smm,
   input wire logic [SMMX_NLP-1:0] launch_leaf,
   input wire logic [SMMX_NLP-1:0] exit_leaf,
   input wire logic [SMMX_NLP-1:0] vmx_leave,
   input wire logic [SMMX_NLP-1:0] smi_pending,
   input wire logic [SMMX_NLP-1:0] at_boundary,
   input wire logic [SMMX_NLP-1:0] long_flow,
   input wire logic [SMMX_NLP-1:0] other_block,
   // Dual-monitor control from the entering logical processor
   input wire logic ent_valid,
   input wire logic [1:0] ent_lp,
   input wire logic ent_deact,
   input wire logic ent_to_smm,
   input wire logic [63:0] exec_ptr,
   input wire logic [63:0] vmx_on_ptr,
   input wire logic guest_smi_block,
   input wire logic act_exit,
   output logic [1:0] ent_res_q,
   output logic exit_load_list_q,
   output logic [SMMX_NLP-1:0] dual_mode_q,
   output logic [SMMX_NLP-1:0] smi_take_q,
   output logic [SMMX_NLP-1:0] ext_state_save_q,
   // Fetch checking
   input wire logic [SMMX_NLP-1:0] fetch_valid,
   input wire logic [63:0] fetch_addr,
   input wire logic [63:0] range_base,
   input wire logic [63:0] range_mask,
   output logic [SMMX_NLP-1:0] mc_q
);
   // ----------------------------------------
   // Package state
   // ----------------------------------------
   logic [63:0] cap_q;
   logic [63:0] ctrl_q;
   logic delay_en_q;
   logic [SMMX_NLP-1:0] smi_block_q;
   logic [SMMX_NLP-1:0] safer_mode;
   logic [SMMX_NLP-1:0] delayed;
   logic [SMMX_NLP-1:0] delay_seen_q;
   logic [SMMX_NLP-1:0] blocked_now;
   logic deact_fail;
   logic req_smm;
   logic guarded;
   logic ctrl_locked;
   assign req_smm = in_smm[msr_lp];
   assign guarded = msr_addr == `SMMX_ADDR_CODE_CTRL || msr_addr == `SMMX_ADDR_DELAY ||
      msr_addr == `SMMX_ADDR_BLOCKED;
   assign ctrl_locked = ctrl_q[`SMMX_CTRL_LOCK_BIT];
   assign deact_fail = !in_smm[ent_lp] || ent_to_smm || exec_ptr != vmx_on_ptr; // RULE3
   assign blocked_now = smi_block_q | other_block;
   // ----------------------------------------
   // Per logical processor trackers
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < SMMX_NLP; g = g + 1) begin : g_lp
         smmx_lp_track u_track (
            .clk(clk),
            .reset(reset),
            .launch_leaf(launch_leaf[g]),
            .exit_leaf(exit_leaf[g]),
            .smi_pending(smi_pending[g]),
            .at_boundary(at_boundary[g]),
            .long_flow(long_flow[g]),
            .safer_mode_q(safer_mode[g]),
            .delayed_q(delayed[g])
         );
         smmx_code_check u_check (
            .clk(clk),
            .reset(reset),
            .check_en(ctrl_q[`SMMX_CTRL_CHK_EN_BIT]), // RULE10
            .in_smm(in_smm[g]),
            .fetch_valid(fetch_valid[g]),
            .fetch_addr(fetch_addr),
            .range_base(range_base),
            .range_mask(range_mask),
            .mc_q(mc_q[g])
         );
      end
   endgenerate
   // ----------------------------------------
   // Capability register
   // ----------------------------------------
   // Read-only; fixed at reset since the features are built in
   always_ff @(posedge clk) begin
      if (reset) begin
         cap_q <= `SMMX_CAP_RESET;
      end
   end
   // ----------------------------------------
   // Code check control register
   // ----------------------------------------
   // Lock bit freezes the register until the next reset
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_q <= `SMMX_CTRL_RESET;
      end else if (msr_wr && req_smm && msr_addr == `SMMX_ADDR_CODE_CTRL) begin // RULE16
         if (cap_q[`SMMX_CAP_CODE_CHK_BIT] && !ctrl_locked) begin // RULE11
            ctrl_q[`SMMX_CTRL_LOCK_BIT] <= msr_wdata[`SMMX_CTRL_LOCK_BIT];
            ctrl_q[`SMMX_CTRL_CHK_EN_BIT] <= msr_wdata[`SMMX_CTRL_CHK_EN_BIT]; // RULE10
         end
      end
   end
   // ----------------------------------------
   // Delay report register
   // ----------------------------------------
   // Status bits are sticky; the set wins over a clearing write
   always_ff @(posedge clk) begin
      if (reset) begin
         delay_en_q <= 1'b0;
         delay_seen_q <= '0;
      end else begin
         if (msr_wr && req_smm && msr_addr == `SMMX_ADDR_DELAY && cap_q[`SMMX_CAP_LONG_FLOW_BIT]) begin // RULE14
            delay_en_q <= msr_wdata[`SMMX_DELAY_EN_BIT]; // RULE13
            delay_seen_q <= (delay_seen_q & msr_wdata[SMMX_NLP-1:0]) | (delayed & {SMMX_NLP{delay_en_q}});
         end else begin
            delay_seen_q <= delay_seen_q | (delayed & {SMMX_NLP{delay_en_q}}); // RULE18
         end
      end
   end
   // ----------------------------------------
   // MSR read and fault answer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         msr_rdata_q <= 64'h0000_0000_0000_0000;
         msr_res_q <= SMMX_RES_NONE;
      end else if (msr_rd || msr_wr) begin // RULE17
         msr_rdata_q <= 64'h0000_0000_0000_0000;
         if (guarded && !req_smm) begin
            msr_res_q <= SMMX_RES_GP; // RULE16
         end else if (msr_addr == `SMMX_ADDR_DELAY && !cap_q[`SMMX_CAP_LONG_FLOW_BIT]) begin
            msr_res_q <= SMMX_RES_GP; // RULE14
         end else if (msr_wr && (msr_addr == `SMMX_ADDR_CAP || msr_addr == `SMMX_ADDR_BLOCKED)) begin
            msr_res_q <= SMMX_RES_GP;
         end else begin
            msr_res_q <= SMMX_RES_OK;
            if (msr_rd) begin
               case (msr_addr)
                  `SMMX_ADDR_CAP: msr_rdata_q <= cap_q;
                  `SMMX_ADDR_CODE_CTRL: msr_rdata_q <= ctrl_q;
                  `SMMX_ADDR_DELAY: msr_rdata_q <= {delay_en_q, {(63-SMMX_NLP){1'b0}}, delay_seen_q}; // RULE13
                  `SMMX_ADDR_BLOCKED: msr_rdata_q <= {{(64-SMMX_NLP){1'b0}}, blocked_now}; // RULE15
                  default: msr_res_q <= SMMX_RES_GP;
               endcase
            end
         end
      end else begin
         msr_res_q <= SMMX_RES_NONE;
      end
   end
   // ----------------------------------------
   // Dual-monitor entry and exit
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         ent_res_q <= SMMX_RES_NONE;
         dual_mode_q <= '0;
         exit_load_list_q <= 1'b0;
      end else begin
         exit_load_list_q <= 1'b0; // RULE1
         ent_res_q <= SMMX_RES_NONE;
         if (act_exit) begin
            dual_mode_q[ent_lp] <= 1'b1;
         end else if (ent_valid && ent_deact) begin
            if (deact_fail) begin
               ent_res_q <= SMMX_RES_FAIL; // RULE3
            end else begin
               ent_res_q <= SMMX_RES_OK;
               dual_mode_q[ent_lp] <= 1'b0; // RULE2
            end
         end
      end
   end
   // ----------------------------------------
   // SMI blocking and delivery
   // ----------------------------------------
   // Guest blocking bit is deliberately not consulted on deactivation
   always_ff @(posedge clk) begin
      if (reset) begin
         smi_block_q <= '0;
         smi_take_q <= '0;
         ext_state_save_q <= '0;
      end else begin
         for (int i = 0; i < SMMX_NLP; i++) begin
            if (ent_valid && ent_deact && !deact_fail && ent_lp == 2'(i)) begin
               smi_block_q[i] <= safer_mode[i]; // RULE4
            end else if (vmx_leave[i] || exit_leaf[i]) begin
               smi_block_q[i] <= 1'b0; // RULE5
            end
            smi_take_q[i] <= smi_pending[i] && at_boundary[i] && !smi_block_q[i] && !in_smm[i]; // RULE12
            ext_state_save_q[i] <= 1'b0; // RULE8
         end
      end
   end
   chk_deact_fail: assert property (@(posedge clk) disable iff (reset)
      ent_valid && ent_deact && !act_exit && deact_fail |=> ent_res_q == SMMX_RES_FAIL) else $error("bad deactivation not failed"); // RULE3
   chk_deact_mode: assert property (@(posedge clk) disable iff (reset)
      ent_valid && ent_deact && !act_exit && !deact_fail |=> ent_res_q == SMMX_RES_OK && !dual_mode_q[$past(ent_lp)]) else $error("deactivation kept dual mode"); // RULE2
   chk_safer_block: assert property (@(posedge clk) disable iff (reset)
      ent_valid && ent_deact && !act_exit && !deact_fail && safer_mode[ent_lp] |=> smi_block_q[$past(ent_lp)]) else $error("safer mode not blocked"); // RULE5
   chk_plain_unblock: assert property (@(posedge clk) disable iff (reset)
      ent_valid && ent_deact && !act_exit && !deact_fail && !safer_mode[ent_lp] && guest_smi_block |=> !smi_block_q[$past(ent_lp)]) else $error("smi left blocked"); // RULE6
   chk_gp_outside: assert property (@(posedge clk) disable iff (reset)
      (msr_rd || msr_wr) && guarded && !req_smm |=> msr_res_q == SMMX_RES_GP) else $error("missing gp fault"); // RULE16
   chk_ctrl_hold: assert property (@(posedge clk) disable iff (reset)
      ctrl_locked |=> ctrl_q == $past(ctrl_q)) else $error("locked control changed"); // RULE11
   chk_no_load: assert property (@(posedge clk) disable iff (reset)
      act_exit |=> !exit_load_list_q) else $error("load list read"); // RULE1
   chk_boundary: assert property (@(posedge clk) disable iff (reset)
      !at_boundary[0] |=> !smi_take_q[0]) else $error("smi taken mid instruction"); // RULE12
   chk_blocked_read: assert property (@(posedge clk) disable iff (reset)
      msr_rd && req_smm && msr_addr == `SMMX_ADDR_BLOCKED |=> msr_rdata_q[SMMX_NLP-1:0] == $past(blocked_now)) else $error("blocked report wrong"); // RULE15
   chk_ctrl_write: assert property (@(posedge clk) disable iff (reset)
      msr_wr && req_smm && msr_addr == `SMMX_ADDR_CODE_CTRL && !ctrl_locked && cap_q[`SMMX_CAP_CODE_CHK_BIT]
      |=> ctrl_q[`SMMX_CTRL_CHK_EN_BIT] == $past(msr_wdata[`SMMX_CTRL_CHK_EN_BIT])) else $error("enable write lost"); // RULE11
   chk_delay_sticky: assert property (@(posedge clk) disable iff (reset)
      delay_en_q && delayed[0] |=> delay_seen_q[0]) else $error("delay not latched"); // RULE13
   chk_req_answer: assert property (@(posedge clk) disable iff (reset)
      msr_rd || msr_wr |=> msr_res_q != SMMX_RES_NONE) else $error("request not answered"); // RULE17
   chk_idle_answer: assert property (@(posedge clk) disable iff (reset)
      !msr_rd && !msr_wr |=> msr_res_q == SMMX_RES_NONE) else $error("answer without request"); // RULE17
   chk_take_blocked: assert property (@(posedge clk) disable iff (reset)
      smi_block_q[1] |=> !smi_take_q[1]) else $error("blocked smi taken"); // RULE5
endmodule
`default_nettype wire

// ===== shared/smmx_map.svh
`ifndef SMMX_MAP_SVH
`define SMMX_MAP_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SMMX_ADDR_CAP 12'h17d
`define SMMX_ADDR_CODE_CTRL 12'h4e0
`define SMMX_ADDR_DELAY 12'h4e2
`define SMMX_ADDR_BLOCKED 12'h4e3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMMX_CAP_CODE_CHK_BIT 58
`define SMMX_CAP_LONG_FLOW_BIT 57
`define SMMX_CTRL_LOCK_BIT 0
`define SMMX_CTRL_CHK_EN_BIT 2
`define SMMX_DELAY_EN_BIT 63
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMMX_CAP_RESET 64'h0600_0000_0000_0000
`define SMMX_CTRL_RESET 64'h0000_0000_0000_0000
`define SMMX_DELAY_RESET 64'h0000_0000_0000_0000
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SMMX_LONG_FLOW_CYCLES 8'h10
`endif

// ===== shared/smmx_pkg.sv
package smmx_pkg;
   localparam int SMMX_NLP = 4;
   typedef enum logic [1:0] {
      SMMX_DM_DEFAULT = 2'b00,
      SMMX_DM_DUAL = 2'b01
   } smmx_mode_t;
   typedef enum logic [1:0] {
      SMMX_RES_NONE = 2'b00,
      SMMX_RES_OK = 2'b01,
      SMMX_RES_FAIL = 2'b10,
      SMMX_RES_GP = 2'b11
   } smmx_res_t;
endpackage

// ===== hw/smmx_lp_track.sv
`timescale 1ns/100ps
`default_nettype none
`include "smmx_map.svh"
module smmx_lp_track
   import smmx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Events
   input wire logic launch_leaf,
   input wire logic exit_leaf,
   input wire logic smi_pending,
   input wire logic at_boundary,
   input wire logic long_flow,
   // Status
   output logic safer_mode_q,
   output logic delayed_q
);
   logic [7:0] wait_q;
   // ----------------------------------------
   // Safer mode tracking
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         safer_mode_q <= 1'b0;
      end else if (launch_leaf) begin
         safer_mode_q <= 1'b1; // RULE7
      end else if (exit_leaf) begin
         safer_mode_q <= 1'b0; // RULE7
      end
   end
   // ----------------------------------------
   // SMI delay detection
   // ----------------------------------------
   // Only a long internal flow counts, not ordinary boundary latency
   always_ff @(posedge clk) begin
      if (reset) begin
         wait_q <= 8'h00;
         delayed_q <= 1'b0;
      end else if (smi_pending && !at_boundary && long_flow) begin
         if (wait_q != `SMMX_LONG_FLOW_CYCLES) begin
            wait_q <= wait_q + 8'h01;
         end else begin
            delayed_q <= 1'b1; // RULE12
         end
      end else begin
         wait_q <= 8'h00;
         delayed_q <= 1'b0;
      end
   end
   chk_safer_launch: assert property (@(posedge clk) disable iff (reset)
      launch_leaf |=> safer_mode_q) else $error("launch leaf did not enter safer mode"); // RULE7
   chk_safer_exit: assert property (@(posedge clk) disable iff (reset)
      exit_leaf && !launch_leaf |=> !safer_mode_q) else $error("exit leaf did not leave safer mode"); // RULE7
endmodule
`default_nettype wire

// ===== hw/smmx_code_check.sv
`timescale 1ns/100ps
`default_nettype none
`include "smmx_map.svh"
module smmx_code_check
   import smmx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Fetch
   input wire logic check_en,
   input wire logic in_smm,
   input wire logic fetch_valid,
   input wire logic [63:0] fetch_addr,
   input wire logic [63:0] range_base,
   input wire logic [63:0] range_mask,
   // Result
   output logic mc_q
);
   logic outside;
   assign outside = (fetch_addr & range_mask) != (range_base & range_mask);
   // ----------------------------------------
   // Fetch range check
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         mc_q <= 1'b0;
      end else begin
         mc_q <= check_en && in_smm && fetch_valid && outside; // RULE9
      end
   end
   chk_fetch_mc: assert property (@(posedge clk) disable iff (reset)
      check_en && in_smm && fetch_valid && outside |=> mc_q) else $error("stray fetch did not raise check"); // RULE9
   chk_fetch_quiet: assert property (@(posedge clk) disable iff (reset)
      !check_en |=> !mc_q) else $error("check raised while disabled"); // RULE9
endmodule
`default_nettype wire

// ===== tb/smmx_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "smmx_map.svh"
module smmx_top_tb
   import smmx_pkg::*;
;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic clk = 1'b0, reset = 1'b1;
   logic msr_rd = 1'b0, msr_wr = 1'b0;
   logic [11:0] msr_addr = 12'h0;
   logic [63:0] msr_wdata = 64'h0;
   logic [1:0] msr_lp = 2'h0, ent_lp = 2'h0;
   logic [63:0] msr_rdata_q;
   logic [1:0] msr_res_q, ent_res_q;
   logic [SMMX_NLP-1:0] in_smm = '1, launch_leaf = '0, exit_leaf = '0, vmx_leave = '0, smi_pending = '0;
   logic [SMMX_NLP-1:0] at_boundary = '0, long_flow = '0, other_block = '0, fetch_valid = '0;
   logic ent_valid = 1'b0, ent_deact = 1'b0, ent_to_smm = 1'b0, guest_smi_block = 1'b0, act_exit = 1'b0;
   logic [63:0] exec_ptr = 64'h0, vmx_on_ptr = 64'h0, fetch_addr = 64'h0;
   logic [63:0] range_base = 64'h0000_0000_1000_0000, range_mask = 64'hffff_ffff_ffff_f000;
   logic exit_load_list_q;
   logic [SMMX_NLP-1:0] dual_mode_q, smi_take_q, ext_state_save_q, mc_q;
   int err_total = 0, tests_run = 0;

   always #2.5 clk = ~clk;

   smmx_top dut (.clk(clk), .reset(reset), .msr_rd(msr_rd), .msr_wr(msr_wr), .msr_addr(msr_addr),
      .msr_wdata(msr_wdata), .msr_lp(msr_lp), .msr_rdata_q(msr_rdata_q), .msr_res_q(msr_res_q),
      .in_smm(in_smm), .launch_leaf(launch_leaf), .exit_leaf(exit_leaf), .vmx_leave(vmx_leave),
      .smi_pending(smi_pending), .at_boundary(at_boundary), .long_flow(long_flow), .other_block(other_block),
      .ent_valid(ent_valid), .ent_lp(ent_lp), .ent_deact(ent_deact), .ent_to_smm(ent_to_smm),
      .exec_ptr(exec_ptr), .vmx_on_ptr(vmx_on_ptr), .guest_smi_block(guest_smi_block), .act_exit(act_exit),
      .ent_res_q(ent_res_q), .exit_load_list_q(exit_load_list_q), .dual_mode_q(dual_mode_q),
      .smi_take_q(smi_take_q), .ext_state_save_q(ext_state_save_q), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .range_base(range_base), .range_mask(range_mask), .mc_q(mc_q));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Request taken at the next edge; answer stands for exactly the following cycle
   task automatic msr(input logic wr, input logic [11:0] a, input logic [63:0] d, input logic [1:0] res,
                      input logic [63:0] rd);
      msr_rd = !wr;
      msr_wr = wr;
      msr_addr = a;
      msr_wdata = d;
      cyc(1);
      msr_rd = 1'b0;
      msr_wr = 1'b0;
      chk(64'(msr_res_q), 64'(res));
      chk(msr_rdata_q, rd);
      // Idle edge keeps back-to-back calls from toggling a strobe twice in one step
      cyc(1);
   endtask

   task automatic deact(input logic [1:0] lp, input logic to_smm, input logic ptr_ok, input logic [1:0] res);
      ent_valid = 1'b1;
      ent_deact = 1'b1;
      ent_lp = lp;
      ent_to_smm = to_smm;
      exec_ptr = 64'h0000_0000_0012_3000;
      vmx_on_ptr = ptr_ok ? 64'h0000_0000_0012_3000 : 64'h0000_0000_0012_4000;
      cyc(1);
      ent_valid = 1'b0;
      chk(64'(ent_res_q), 64'(res));
      cyc(1);
   endtask

   task automatic activate(input logic [1:0] lp);
      act_exit = 1'b1;
      ent_lp = lp;
      cyc(1);
      act_exit = 1'b0;
      chk(64'(dual_mode_q[lp]), 64'h1);
      chk(64'(exit_load_list_q), 64'h0);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      msr(1'b0, `SMMX_ADDR_CAP, 64'h0, SMMX_RES_OK, 64'h0600_0000_0000_0000);
      msr(1'b1, `SMMX_ADDR_CAP, 64'h1, SMMX_RES_GP, 64'h0);
      msr(1'b0, 12'h4e1, 64'h0, SMMX_RES_GP, 64'h0);
      msr(1'b1, `SMMX_ADDR_BLOCKED, 64'h0, SMMX_RES_GP, 64'h0);
      msr(1'b0, `SMMX_ADDR_DELAY, 64'h0, SMMX_RES_OK, 64'h0);
      in_smm = 4'b1110;
      msr(1'b0, `SMMX_ADDR_CODE_CTRL, 64'h0, SMMX_RES_GP, 64'h0);
      msr(1'b1, `SMMX_ADDR_CODE_CTRL, 64'h4, SMMX_RES_GP, 64'h0);
      msr(1'b0, `SMMX_ADDR_DELAY, 64'h0, SMMX_RES_GP, 64'h0);
      msr(1'b1, `SMMX_ADDR_DELAY, 64'h0, SMMX_RES_GP, 64'h0);
      msr(1'b0, `SMMX_ADDR_BLOCKED, 64'h0, SMMX_RES_GP, 64'h0);
      in_smm = '1;
      msr(1'b0, `SMMX_ADDR_CODE_CTRL, 64'h0, SMMX_RES_OK, 64'h0);
   endtask

   // Lock is set last; only a reset releases it
   task automatic t_code_check();
      fetch_valid = 4'b0001;
      fetch_addr = 64'h0000_0000_2000_0000;
      cyc(2);
      chk(64'(mc_q), 64'h0);
      msr(1'b1, `SMMX_ADDR_CODE_CTRL, 64'h4, SMMX_RES_OK, 64'h0);
      msr(1'b0, `SMMX_ADDR_CODE_CTRL, 64'h0, SMMX_RES_OK, 64'h4);
      cyc(1);
      chk(64'(mc_q), 64'h1);
      fetch_addr = 64'h0000_0000_1000_0abc;
      cyc(2);
      chk(64'(mc_q), 64'h0);
      fetch_valid = '0;
      msr(1'b1, `SMMX_ADDR_CODE_CTRL, 64'h5, SMMX_RES_OK, 64'h0);
      msr(1'b1, `SMMX_ADDR_CODE_CTRL, 64'h0, SMMX_RES_OK, 64'h0);
      msr(1'b0, `SMMX_ADDR_CODE_CTRL, 64'h0, SMMX_RES_OK, 64'h5);
   endtask

   task automatic t_deact_fail();
      activate(2'd1);
      in_smm = 4'b1101;
      deact(2'd1, 1'b0, 1'b1, SMMX_RES_FAIL);
      in_smm = '1;
      deact(2'd1, 1'b1, 1'b1, SMMX_RES_FAIL);
      deact(2'd1, 1'b0, 1'b0, SMMX_RES_FAIL);
      chk(64'(dual_mode_q), 64'h2);
   endtask

   // Guest blocking bit is held high throughout; only safer mode may block afterwards
   task automatic t_safer_block();
      guest_smi_block = 1'b1;
      launch_leaf = 4'b0010;
      cyc(1);
      launch_leaf = '0;
      deact(2'd1, 1'b0, 1'b1, SMMX_RES_OK);
      chk(64'(dual_mode_q), 64'h0);
      other_block = 4'b1000;
      msr_lp = 2'd1;
      msr(1'b0, `SMMX_ADDR_BLOCKED, 64'h0, SMMX_RES_OK, 64'ha);
      msr_lp = 2'd0;
      other_block = '0;
      in_smm = 4'b1101;
      smi_pending = 4'b0010;
      at_boundary = 4'b0010;
      cyc(2);
      chk(64'(smi_take_q), 64'h0);
      vmx_leave = 4'b0010;
      cyc(1);
      vmx_leave = '0;
      cyc(2);
      chk(64'(smi_take_q), 64'h2);
      chk(64'(ext_state_save_q), 64'h0);
      smi_pending = '0;
      in_smm = '1;
   endtask

   task automatic t_unsafe_unblock();
      launch_leaf = 4'b0010;
      cyc(1);
      launch_leaf = '0;
      exit_leaf = 4'b0010;
      cyc(1);
      exit_leaf = '0;
      activate(2'd1);
      deact(2'd1, 1'b0, 1'b1, SMMX_RES_OK);
      msr(1'b0, `SMMX_ADDR_BLOCKED, 64'h0, SMMX_RES_OK, 64'h0);
      in_smm = 4'b1101;
      smi_pending = 4'b0010;
      cyc(2);
      chk(64'(smi_take_q), 64'h2);
      chk(64'(ext_state_save_q), 64'h0);
      smi_pending = '0;
      at_boundary = '0;
      in_smm = '1;
   endtask

   task automatic t_delay();
      msr(1'b1, `SMMX_ADDR_DELAY, 64'h8000_0000_0000_0000, SMMX_RES_OK, 64'h0);
      smi_pending = 4'b1000;
      long_flow = 4'b1000;
      cyc(10);
      smi_pending = 4'b0100;
      long_flow = 4'b0100;
      msr(1'b0, `SMMX_ADDR_DELAY, 64'h0, SMMX_RES_OK, 64'h8000_0000_0000_0000);
      cyc(20);
      smi_pending = '0;
      long_flow = '0;
      msr(1'b0, `SMMX_ADDR_DELAY, 64'h0, SMMX_RES_OK, 64'h8000_0000_0000_0004);
      msr(1'b1, `SMMX_ADDR_DELAY, 64'h8000_0000_0000_0000, SMMX_RES_OK, 64'h0);
      msr(1'b0, `SMMX_ADDR_DELAY, 64'h0, SMMX_RES_OK, 64'h8000_0000_0000_0000);
   endtask

   // ----------------------------------------
   // Verdict and sequence
   // ----------------------------------------
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // The whole sequence needs about 120 cycles; this leaves ample margin
   initial begin
      #50000;
      err_total++;
      print_verdict();
   end

   initial begin
      cyc(16);
      reset = 1'b0;
      t_regs();
      t_code_check();
      t_deact_fail();
      t_safer_block();
      t_unsafe_unblock();
      t_delay();
      print_verdict();
   end
endmodule
`default_nettype wire
